// >>> logic/blcfg_pkg.sv
// Purpose: Shared constants and carriers for the backlight configuration registers.
// Assumes: 100 MHz mclk; register access by 8-bit address on a simple write/read port.
// Notes: Reset values are plain defaults; the idle timeout is set in milliseconds and scaled to a cycle count.
package blcfg_pkg;
    localparam logic [7:0] ADDR_LIMIT_MSB = 8'ha1;
    localparam logic [7:0] ADDR_PROT_SRC = 8'ha2;
    localparam logic [7:0] RESET_LIMIT_MSB = 8'h00;
    localparam logic [7:0] RESET_PROT_SRC = 8'h00;
    localparam int BIT_IDLE_STBY = 7;
    localparam int POS_MAX_CUR = 4;
    localparam int POS_CUR_MSB = 0;
    localparam int BIT_UNDERVOLTAGE_LOCKOUT_ENABLE = 5;
    localparam int BIT_UNDERVOLTAGE_THRESHOLD_SELECT = 4;
    localparam int BIT_BL_EN = 3;
    localparam int BIT_RES_SEL = 2;
    localparam int BIT_SW_PIN = 1;
    localparam int BIT_DIM_PIN = 0;
    localparam logic [7:0] PROT_SRC_WMASK = 8'h3f;
    localparam int IDLE_TIMEOUT_MS = 50;
    localparam int CLK_HZ = 100_000_000;
    localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } blcfg_req_t;

    typedef struct packed {
        logic [2:0] max_current_code;
        logic [11:0] current_code;
        logic current_from_resistor;
        logic undervoltage_lockout_enable;
        logic undervoltage_threshold_select;
        logic backlight_enable;
        logic [1:0] switcher_rate;
        logic [1:0] dimming_rate;
        logic standby;
    } blcfg_ctrl_t;
endpackage : blcfg_pkg

// >>> logic/blcfg_regs.sv
// Purpose: Two configuration registers steering current, protection and rate sources.
// Assumes: Serial front end decodes register writes/reads into req; pins are asynchronous.
// Notes: Standby is entered after the dimming input idles low for the timeout.
// Behaviour
// - With the idle-standby bit set, the device enters standby after the PWM input stays low ~50 ms.
// - First register bits 3:0 are the current code's top four bits and 6:4 the maximum current.
// - Second register bit 5 enables undervoltage lockout and bit 4 picks 2.5 V (0) or 5.2 V (1).
// - Second register bit 3 enables the backlight and must be set for PWM-only control.
// - Second register bit 1 takes the switching rate from the select pin, else from storage.
// - Second register bit 0 takes the dimming rate from the select pin, else from storage.
// - The current-set select bit picks the resistor pin scaling or the stored current fields.
`timescale 1ns/1ps
module blcfg_regs #(
    parameter int IDLE_CYCLES = blcfg_pkg::IDLE_TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire blcfg_pkg::blcfg_req_t req,
    output logic [7:0] rdata,
    input wire logic [7:0] current_low_byte,
    input wire logic [1:0] stored_switcher_rate,
    input wire logic [1:0] stored_dimming_rate,
    input wire logic [1:0] frequency_select_pin,
    input wire logic pwm_in,
    output blcfg_pkg::blcfg_ctrl_t ctrl
);
    import blcfg_pkg::*;

    // Pin bits that cross into mclk: bit 0 is the PWM input, bits 2:1 the select pin
    localparam int SYNC_BITS = 3;

    // Register selects, shared by the write path and the read path
    function automatic logic hits_limit_msb(input logic [7:0] addr);
        return addr == ADDR_LIMIT_MSB;
    endfunction : hits_limit_msb

    function automatic logic hits_prot_src(input logic [7:0] addr);
        return addr == ADDR_PROT_SRC;
    endfunction : hits_prot_src

    logic [7:0] current_limit_and_msb_config;
    logic [7:0] protection_and_source_config;
    logic [7:0] next_rdata;
    logic wr_limit_msb;
    logic wr_prot_src;
    logic [SYNC_BITS-1:0] pin_raw;
    logic [SYNC_BITS-1:0] pin_s1;
    logic [SYNC_BITS-1:0] pin_s2;
    logic [SYNC_BITS-1:0] pin_s3;
    logic [SYNC_BITS-1:0] pin_stable;
    logic pwm_stable;
    logic [1:0] fsel_stable;
    logic [31:0] idle_count;
    logic idle_restart;
    logic idle_expired;
    logic standby;

    assign wr_limit_msb = req.wr && hits_limit_msb(req.addr);
    assign wr_prot_src = req.wr && hits_prot_src(req.addr);

    // Writes to any other address fall through untouched
    always_ff @(posedge mclk) begin
        if (rst) begin
            current_limit_and_msb_config <= RESET_LIMIT_MSB;
        end else if (wr_limit_msb) begin
            current_limit_and_msb_config <= req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            protection_and_source_config <= RESET_PROT_SRC;
        end else if (wr_prot_src) begin
            // Reserved bits held at zero so reads never depend on them
            protection_and_source_config <= req.wdata & PROT_SRC_WMASK;
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        next_rdata = 8'h00;
        if (hits_limit_msb(req.addr)) begin
            next_rdata = current_limit_and_msb_config;
        end else if (hits_prot_src(req.addr)) begin
            next_rdata = protection_and_source_config;
        end else begin
            next_rdata = 8'h00;
        end
    end

    // A read in the same cycle as a write returns the value before that write
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            rdata <= next_rdata;
        end
    end

    assign pin_raw = {frequency_select_pin, pwm_in};

    // One synchroniser per pin bit; a level counts once stages two and three agree,
    // which costs a cycle of latency but keeps a half-settled pin out of the rate mux
    for (genvar i = 0; i < SYNC_BITS; i++) begin : g_sync
        always_ff @(posedge mclk) begin
            if (rst) begin
                pin_s1[i] <= 1'b0;
                pin_s2[i] <= 1'b0;
                pin_s3[i] <= 1'b0;
                pin_stable[i] <= 1'b0;
            end else begin
                pin_s1[i] <= pin_raw[i];
                pin_s2[i] <= pin_s1[i];
                pin_s3[i] <= pin_s2[i];
                if (pin_s2[i] == pin_s3[i]) begin
                    pin_stable[i] <= pin_s3[i];
                end
            end
        end
    end

    assign pwm_stable = pin_stable[0];
    assign fsel_stable = pin_stable[2:1];

    // Idle detector; any high level, or the enable bit clear, restarts the timeout
    assign idle_restart = !current_limit_and_msb_config[BIT_IDLE_STBY] || pwm_stable;
    assign idle_expired = idle_count >= 32'(IDLE_CYCLES - 1);

    // The count saturates so a long idle spell never wraps back out of standby
    always_ff @(posedge mclk) begin
        if (rst) begin
            idle_count <= 32'h0;
        end else if (idle_restart) begin
            idle_count <= 32'h0;
        end else if (!idle_expired) begin
            idle_count <= idle_count + 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            standby <= 1'b0;
        end else if (idle_restart) begin
            standby <= 1'b0;
        end else if (idle_expired) begin
            standby <= 1'b1;
        end
    end

    // Control outputs, each from its own flop so the analog side sees clean levels
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl.max_current_code <= 3'h0;
        end else begin
            ctrl.max_current_code <= current_limit_and_msb_config[POS_MAX_CUR +: 3];
        end
    end

    // The low byte lives in another register and is only paired up here
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl.current_code <= 12'h000;
        end else begin
            ctrl.current_code <= {current_limit_and_msb_config[POS_CUR_MSB +: 4],
                                  current_low_byte};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl.current_from_resistor <= 1'b0;
        end else begin
            ctrl.current_from_resistor <= protection_and_source_config[BIT_RES_SEL];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl.undervoltage_lockout_enable <= 1'b0;
        end else begin
            ctrl.undervoltage_lockout_enable <= protection_and_source_config[BIT_UNDERVOLTAGE_LOCKOUT_ENABLE];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl.undervoltage_threshold_select <= 1'b0;
        end else begin
            ctrl.undervoltage_threshold_select <= protection_and_source_config[BIT_UNDERVOLTAGE_THRESHOLD_SELECT];
        end
    end

    // This bit resets clear, so backlight_enable stays low until a master writes it
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl.backlight_enable <= 1'b0;
        end else begin
            ctrl.backlight_enable <= protection_and_source_config[BIT_BL_EN];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl.switcher_rate <= 2'h0;
        end else if (protection_and_source_config[BIT_SW_PIN]) begin
            ctrl.switcher_rate <= fsel_stable;
        end else begin
            ctrl.switcher_rate <= stored_switcher_rate;
        end
    end

    // Both rates share one select pin; a user setting both pin bits gets one code twice
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl.dimming_rate <= 2'h0;
        end else if (protection_and_source_config[BIT_DIM_PIN]) begin
            ctrl.dimming_rate <= fsel_stable;
        end else begin
            ctrl.dimming_rate <= stored_dimming_rate;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl.standby <= 1'b0;
        end else begin
            ctrl.standby <= standby;
        end
    end
endmodule : blcfg_regs

// >>> verification/blcfg_host.sv
// Purpose: host model. Assumes: bench gives intent. Notes: requests pass with no delay.
`timescale 1ns/1ps
module blcfg_host (
    input wire logic wr,
    input wire logic rd,
    input wire logic raw,
    input wire logic [7:0] addr,
    input wire logic [7:0] data,
    output blcfg_pkg::blcfg_req_t req
);
    import blcfg_pkg::*;
    // A polite host zeroes reserved bits; raw lets a test send them set anyway
    wire logic [7:0] d = (addr == ADDR_PROT_SRC && !raw) ? data & PROT_SRC_WMASK : data;
    assign req = '{wr, rd, addr, d};
endmodule : blcfg_host

// >>> verification/blcfg_checker.sv
// Purpose: port assertions. Assumes: one clock. Notes: bound below.
`timescale 1ns/1ps
module blcfg_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire blcfg_pkg::blcfg_req_t req,
    input wire logic [1:0] stored_switcher_rate,
    input wire logic pwm_in,
    input wire blcfg_pkg::blcfg_ctrl_t ctrl
);
    import blcfg_pkg::*;
    logic [7:0] d1, d2;
    wire wa = req.wr && req.addr == ADDR_LIMIT_MSB;
    wire wb = req.wr && req.addr == ADDR_PROT_SRC;
    // Write data two edges old, in step with the ctrl flop
    always_ff @(posedge mclk) begin
        d1 <= req.wdata;
        d2 <= d1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_cur_max: assert property (wa |-> ##2 ctrl.max_current_code == d2[6:4])
        else $error("max");
    a_cur_msb: assert property (wa |-> ##2 ctrl.current_code[11:8] == d2[3:0])
        else $error("msb");
    a_undervoltage_lockout_enable: assert property (wb |-> ##2 ctrl.undervoltage_lockout_enable == d2[5])
        else $error("uv");
    a_undervoltage_threshold_select: assert property (wb |-> ##2 ctrl.undervoltage_threshold_select == d2[4])
        else $error("th");
    a_bl_en: assert property (wb |-> ##2 ctrl.backlight_enable == d2[3])
        else $error("bl");
    a_res_sel: assert property (wb |-> ##2 ctrl.current_from_resistor == d2[2])
        else $error("res");
    a_sw_stored: assert property (wb && !req.wdata[1] |-> ##2
        ctrl.switcher_rate == $past(stored_switcher_rate)) else $error("sw");
    a_stby_drop: assert property (pwm_in [*8] |=> !ctrl.standby) else $error("stby");
    cover property (wa);
    cover property (wb);
    cover property ($rose(ctrl.standby));
endmodule : blcfg_checker
bind blcfg_regs blcfg_checker chk_i (.mclk, .rst, .req, .stored_switcher_rate, .pwm_in, .ctrl);

// >>> verification/backlight_config_regs_tb.sv
// Purpose: register bench. Assumes: idle timeout of 20. Notes: reads checked from a queue.
`timescale 1ns/1ps
module backlight_config_regs_tb;
    import blcfg_pkg::*;
    logic mclk = 0, rst = 1, wr = 0, rd = 0, raw = 0, pwm_in = 1, seen = 0;
    logic [7:0] addr = 0, data = 0, low = 0, rdata, v1, v2;
    logic [5:0] rt = 0;
    blcfg_req_t req;
    blcfg_ctrl_t ctrl;
    logic [7:0] expq[$];
    int num_errors = 0, check_count = 0, cyc = 0, seed = 78662;
    always #5 mclk = ~mclk;
    blcfg_host host (.wr(wr), .rd(rd), .raw(raw), .addr(addr), .data(data), .req(req));
    blcfg_regs #(.IDLE_CYCLES(20)) uut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
        .current_low_byte(low), .stored_switcher_rate(rt[5:4]), .stored_dimming_rate(rt[3:2]),
        .frequency_select_pin(rt[1:0]), .pwm_in(pwm_in), .ctrl(ctrl));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %h vs %h", $time, got, exp);
        end
    endtask : chk
    task give_verdict;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task op(input logic w, r, input logic [7:0] a, d, e);
        {wr, rd, addr, data} <= {w, r, a, d};
        if (r) expq.push_back(e);
        @(posedge mclk);
    endtask : op
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 0;
        for (int i = 0; i < 8; i++) begin
            v1 = 8'($random(seed)) & 8'h7f;
            v2 = 8'($random(seed));
            {low, rt} <= 14'($random(seed));
            raw <= i[0];
            op(1, 0, ADDR_LIMIT_MSB, v1, 0);
            op(1, 0, ADDR_PROT_SRC, v2, 0);
            op(0, 1, ADDR_PROT_SRC, 0, v2 & PROT_SRC_WMASK);
            op(0, 1, ADDR_LIMIT_MSB, 0, v1);
            op(0, 1, 8'ha3, 0, 0);
            repeat (6) op(0, 0, 0, 0, 0);
            chk({ctrl.max_current_code, ctrl.current_code}, {v1[6:0], low});
            chk(ctrl[8:5], {v2[2], v2[5:3]});
            chk(ctrl.switcher_rate, v2[1] ? rt[1:0] : rt[5:4]);
            chk(ctrl.dimming_rate, v2[0] ? rt[1:0] : rt[3:2]);
        end
        pwm_in <= 0;
        op(1, 0, ADDR_PROT_SRC, 8'h00, 0);
        op(1, 0, ADDR_LIMIT_MSB, 8'h80, 0);
        op(0, 0, 0, 0, 0);
        repeat (40) @(posedge mclk);
        chk(ctrl.backlight_enable, 0);
        chk(ctrl.standby, 1);
        pwm_in <= 1;
        repeat (8) @(posedge mclk);
        chk(ctrl.standby, 0);
        give_verdict();
    end
    always @(posedge mclk) begin
        seen <= rd;
        if (seen) chk(rdata, expq.pop_front());
        if (++cyc == 2000) begin
            num_errors++;
            give_verdict();
        end
    end
endmodule : backlight_config_regs_tb
